// ---- rtl/script_chain_pkg.sv ----
// constants for the script and shift chain status register bank
package script_chain_pkg;
	localparam logic [15:0] chain_config_addr = 16'h0025;
	localparam logic [15:0] chain_assignment_state_addr = 16'h0026;
	localparam logic [15:0] script_run_enable_addr = 16'h0032;
	localparam logic [15:0] script_port_select_addr = 16'h0033;
	localparam logic [15:0] script_state_addr = 16'h0034;
	localparam logic [15:0] script_pass_counter_addr = 16'h0035;
	localparam logic [15:0] chain_link_error_addr = 16'h0036;
	localparam logic [7:0] chain_config_reset = 8'h03;
	localparam logic [7:0] script_run_enable_reset = 8'h00;
	localparam logic [7:0] script_port_select_reset = 8'h01;
	localparam logic [15:0] script_pass_counter_reset = 16'h0000;
	localparam int out_led_bit = 0;
	localparam int in_switch_lsb = 1;
	localparam logic [2:0] chain_config_mask = 3'h7;
	localparam logic [7:0] state_init = 8'h00;
	localparam logic [7:0] state_running = 8'h01;
	localparam logic [7:0] state_waiting = 8'h02;
	localparam logic [7:0] state_stopped = 8'h03;
	localparam logic [7:0] state_error = 8'h04;
	localparam logic [7:0] chain_err_max = 8'h05;
	localparam logic port_config_debug = 1'b0;
	localparam logic port_serial_data = 1'b1;
endpackage

// ---- rtl/script_state_tracker.sv ----
// script state and pass counter tracking
`timescale 1ns/1ns
`default_nettype none
module script_state_tracker #(
	parameter int count_width = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// script engine events
	input wire logic script_enabled,
	input wire logic script_loaded,
	input wire logic script_init_done,
	input wire logic script_wait,
	input wire logic script_fault,
	input wire logic script_pass,
	// status
	output logic [7:0] state,
	output logic [count_width-1:0] pass_count
);
	typedef enum {st_init, st_run, st_wait, st_stop, st_err} sstate_t;
	sstate_t st_q, st_d;
	logic [count_width-1:0] cnt_q, cnt_d;

	always_comb begin
		st_d = st_q;
		case (st_q)
			st_init: begin
				if (script_init_done)
					st_d = st_run;
			end
			st_run: begin
				if (script_wait)
					st_d = st_wait;
			end
			st_wait: begin
				if (!script_wait)
					st_d = st_run;
			end
			st_stop: begin
				if (script_enabled && script_loaded)
					st_d = st_init;
			end
			st_err: st_d = st_err;
			default: st_d = st_stop;
		endcase
		if (!script_enabled || !script_loaded)
			st_d = st_stop;
		if (script_fault)
			st_d = st_err;
		cnt_d = cnt_q;
		if (script_pass && (st_q == st_run || st_q == st_wait))
			cnt_d = cnt_q + 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q <= st_stop;
			cnt_q <= count_width'(script_chain_pkg::script_pass_counter_reset);
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end

	always_comb begin
		case (st_q)
			st_init: state = script_chain_pkg::state_init;
			st_run: state = script_chain_pkg::state_running;
			st_wait: state = script_chain_pkg::state_waiting;
			st_stop: state = script_chain_pkg::state_stopped;
			st_err: state = script_chain_pkg::state_error;
			default: state = script_chain_pkg::state_stopped;
		endcase
	end
	assign pass_count = cnt_q;
endmodule
`default_nettype wire

// ---- rtl/script_chain_regs.sv ----
// register bank for shift chain assignment and script control
`timescale 1ns/1ns
`default_nettype none
module script_chain_regs (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// register access from the host protocol engine
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// stored values restored at start, taken while restart_load is high
	input wire logic restart_load,
	input wire logic [7:0] stored_chain_config,
	input wire logic [7:0] stored_script_enable,
	input wire logic [7:0] stored_script_port,
	// script engine
	input wire logic script_loaded,
	input wire logic script_init_done,
	input wire logic script_wait,
	input wire logic script_fault,
	input wire logic script_pass,
	output logic script_run,
	output logic script_on_serial_data_port,
	// shift register chain
	input wire logic [7:0] chain_link_error,
	output logic out_reg0_leds,
	output logic [1:0] in_switch_regs,
	// config debug port menu
	output logic config_debug_menu_enable
);
	logic [7:0] cfg_q, cfg_d;
	logic [7:0] asg_q, asg_d;
	logic [7:0] en_q, en_d;
	logic [7:0] port_q, port_d;
	logic [7:0] run_en_q, run_en_d;
	logic run_port_q, run_port_d;
	logic [15:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic [7:0] state;
	logic [15:0] pass_count;
	logic [7:0] err_code;

	script_state_tracker #(
		.count_width(16)
	) u_tracker (
		.sys_clk(sys_clk),
		.srst(srst),
		.script_enabled(script_run),
		.script_loaded(script_loaded),
		.script_init_done(script_init_done),
		.script_wait(script_wait),
		.script_fault(script_fault),
		.script_pass(script_pass),
		.state(state),
		.pass_count(pass_count)
	);

	always_comb begin
		cfg_d = cfg_q;
		asg_d = asg_q;
		en_d = en_q;
		port_d = port_q;
		run_en_d = run_en_q;
		run_port_d = script_run ? run_port_q : port_q[0];
		if (restart_load) begin
			cfg_d = stored_chain_config;
			asg_d = {5'h00, stored_chain_config[2:0] & script_chain_pkg::chain_config_mask};
			en_d = stored_script_enable;
			port_d = stored_script_port;
			run_en_d = stored_script_enable;
			run_port_d = stored_script_port[0];
		end else if (reg_wr) begin
			case (reg_addr)
				script_chain_pkg::chain_config_addr: cfg_d = reg_wdata[7:0];
				script_chain_pkg::chain_assignment_state_addr: asg_d = {5'h00, reg_wdata[2:0]};
				script_chain_pkg::script_run_enable_addr: begin
					en_d = reg_wdata[7:0];
					if (!script_run || run_port_q == script_chain_pkg::port_serial_data)
						run_en_d = reg_wdata[7:0];
				end
				script_chain_pkg::script_port_select_addr: begin
					port_d = reg_wdata[7:0];
					if (!script_run)
						run_port_d = reg_wdata[0];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_q <= script_chain_pkg::chain_config_reset;
			asg_q <= script_chain_pkg::chain_config_reset;
			en_q <= script_chain_pkg::script_run_enable_reset;
			port_q <= script_chain_pkg::script_port_select_reset;
			run_en_q <= script_chain_pkg::script_run_enable_reset;
			run_port_q <= script_chain_pkg::script_port_select_reset[0];
		end else begin
			cfg_q <= cfg_d;
			asg_q <= asg_d;
			en_q <= en_d;
			port_q <= port_d;
			run_en_q <= run_en_d;
			run_port_q <= run_port_d;
		end
	end

	assign err_code = (chain_link_error > script_chain_pkg::chain_err_max) ?
		script_chain_pkg::chain_err_max : chain_link_error;

	always_comb begin
		rvalid_d = reg_rd;
		rdata_d = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				script_chain_pkg::chain_config_addr: rdata_d = {8'h00, cfg_q};
				script_chain_pkg::chain_assignment_state_addr: rdata_d = {8'h00, asg_q};
				script_chain_pkg::script_run_enable_addr: rdata_d = {8'h00, en_q};
				script_chain_pkg::script_port_select_addr: rdata_d = {8'h00, port_q};
				script_chain_pkg::script_state_addr: rdata_d = {8'h00, state};
				script_chain_pkg::script_pass_counter_addr: rdata_d = pass_count;
				script_chain_pkg::chain_link_error_addr: rdata_d = {8'h00, err_code};
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign script_run = (run_en_q == 8'h01);
	assign script_on_serial_data_port = run_port_q;
	assign out_reg0_leds = asg_q[script_chain_pkg::out_led_bit];
	assign in_switch_regs = asg_q[script_chain_pkg::in_switch_lsb +: 2];
	assign config_debug_menu_enable =
		!(script_run && run_port_q == script_chain_pkg::port_config_debug);
endmodule
`default_nettype wire

// ---- verif/scr_checker.sv ----
// assertions on the script and shift chain register bank ports
`timescale 1ns/1ns
`default_nettype none
module scr_checker (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic restart_load,
	input wire logic [7:0] chain_link_error,
	input wire logic script_run,
	input wire logic script_on_serial_data_port,
	input wire logic out_reg0_leds,
	input wire logic [1:0] in_switch_regs,
	input wire logic config_debug_menu_enable
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	a_led_bit: assert property (reg_wr && reg_addr == 16'h0026 && !restart_load |=>
		out_reg0_leds == $past(reg_wdata[0])) else $error("led bit wrong");
	a_switch_bits: assert property (reg_wr && reg_addr == 16'h0026 && !restart_load |=>
		in_switch_regs == $past(reg_wdata[2:1])) else $error("switch bits wrong");
	a_run_on: assert property (reg_wr && reg_addr == 16'h0032 && reg_wdata[7:0] == 8'h01 && !restart_load
		&& !script_run |=> script_run) else $error("script not enabled");
	a_port_sel: assert property (reg_wr && reg_addr == 16'h0033 && !script_run && !restart_load |=>
		script_on_serial_data_port == $past(reg_wdata[0])) else $error("port select wrong");
	a_menu_off: assert property (config_debug_menu_enable ==
		!(script_run && !script_on_serial_data_port)) else $error("menu offered wrongly");
	a_run_hold: assert property (script_run && !script_on_serial_data_port && !restart_load |=>
		script_run) else $error("script dropped without restart");
	a_state_range: assert property (reg_rd && reg_addr == 16'h0034 |=>
		reg_rvalid && reg_rdata <= 16'h0004) else $error("state out of range");
	a_err_clamp: assert property (reg_rd && reg_addr == 16'h0036 |=> reg_rvalid && reg_rdata ==
		($past(chain_link_error) > 8'h05 ? 16'h0005 : {8'h00, $past(chain_link_error)})) else $error("error code wrong");
endmodule
bind script_chain_regs scr_checker u_chk (.sys_clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
	.reg_rvalid, .restart_load, .chain_link_error, .script_run, .script_on_serial_data_port, .out_reg0_leds,
	.in_switch_regs, .config_debug_menu_enable);
`default_nettype wire

// ---- verif/modbus_host.sv ----
// host model issuing register reads and writes
`timescale 1ns/1ns
`default_nettype none
module modbus_host (
	input wire logic sys_clk,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	output logic [15:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_wdata
);
	initial begin
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~v;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		while (!reg_rvalid)
			@(posedge sys_clk);
		v = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the script and shift chain register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic sys_clk, srst, reg_wr, reg_rd, reg_rvalid, restart_load, script_loaded, script_init_done, script_wait;
	logic script_fault, script_pass, script_run, script_on_serial_data_port, out_reg0_leds, config_debug_menu_enable;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [7:0] stored_chain_config, stored_script_enable, stored_script_port, chain_link_error;
	logic [1:0] in_switch_regs;
	int failures, samples_checked, cyc;
	logic [15:0] ra[9] = '{16'h0032, 16'h0033, 16'h0035, 16'h0025, 16'h0033, 16'h0034, 16'h0040, 16'h0025, 16'h0026};
	logic [15:0] rw[9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0000, 16'h0055, 16'h00ff, 16'h0006, 16'h0005};
	logic [15:0] re[9] = '{16'h0000, 16'h0001, 16'h0000, 16'h0003, 16'h0000, 16'h0003, 16'h0000, 16'h0006, 16'h0005};
	script_chain_regs u_dut (.sys_clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
		.restart_load, .stored_chain_config, .stored_script_enable, .stored_script_port, .script_loaded,
		.script_init_done, .script_wait, .script_fault, .script_pass, .script_run, .script_on_serial_data_port,
		.chain_link_error, .out_reg0_leds, .in_switch_regs, .config_debug_menu_enable);
	modbus_host h (.sys_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic final_report;
		if (failures == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 80000) begin
			failures++;
			final_report;
		end
	end
	initial begin
		{srst, restart_load, script_loaded, script_init_done, script_wait, script_fault, script_pass} = 7'h40;
		{stored_chain_config, stored_script_enable, stored_script_port, chain_link_error} = 32'h03000102;
		step(10);
		srst <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (i > 3) h.wr(ra[i], rw[i]);
			h.rd(ra[i], d);
			chk(d, re[i]);
		end
		chk(16'(out_reg0_leds), 16'h0001);
		chk(16'(in_switch_regs), 16'h0002);
		h.wr(16'h0032, 16'h0001);
		step(1);
		chk(16'(config_debug_menu_enable), 16'h0000);
		h.wr(16'h0032, 16'h0000);
		h.rd(16'h0032, d);
		chk(d, 16'h0000);
		chk(16'(script_run), 16'h0001);
		restart_load <= 1'b1;
		step(1);
		restart_load <= 1'b0;
		step(1);
		chk(16'({script_run, config_debug_menu_enable, script_on_serial_data_port}), 16'h0003);
		h.rd(16'h0026, d);
		chk(d, 16'h0003);
		h.rd(16'h0036, d);
		chk(d, 16'h0002);
		chain_link_error <= 8'h07;
		h.rd(16'h0036, d);
		chk(d, 16'h0005);
		script_loaded <= 1'b1;
		h.wr(16'h0032, 16'h0001);
		h.rd(16'h0034, d);
		chk(d, 16'h0000);
		script_init_done <= 1'b1;
		step(1);
		script_init_done <= 1'b0;
		h.rd(16'h0034, d);
		chk(d, 16'h0001);
		script_pass <= 1'b1;
		step(3);
		script_pass <= 1'b0;
		h.rd(16'h0035, d);
		chk(d, 16'h0003);
		script_pass <= 1'b1;
		step(65533);
		script_pass <= 1'b0;
		h.rd(16'h0035, d);
		chk(d, 16'h0000);
		script_wait <= 1'b1;
		h.rd(16'h0034, d);
		chk(d, 16'h0002);
		script_fault <= 1'b1;
		h.rd(16'h0034, d);
		chk(d, 16'h0004);
		final_report;
	end
endmodule
`default_nettype wire
